// file: tctl_core.sv
// Output assignment and ON/OFF temperature control with AHB-Lite registers.
`timescale 1ns/1ps
`default_nettype none
`include "tctl_defines.svh"

// Functional notes
// - Each of four outputs follows its own function selector.
// - Normally open alarm outputs close on alarm: silenceable, fixed, latched.
// - Inverted alarm outputs open on alarm with the same three behaviours.
// - Instrument-on output is active in ON state, inactive in stand-by.
// - Shop light output is on in Normal mode, off in Eco mode.
// - Internal light follows the open door when an input is a door sensor.
// - Heater output is the heating actuator of neutral-zone control.
// - Auxiliary mode off keeps the auxiliary output inactive.
// - Mode 1 turns auxiliary on after a delay from compressor on.
// - Mode 2 toggles auxiliary on key or input command; clock events switch.
// - Mode 2 auxiliary timer switches output off when set and expired.
// - Key or input command forces auxiliary state until next clock event.
// - Mode 3 keeps auxiliary on in control, off during defrost phases.
// - Buzzer selector: off, alarms only, keys only, or both.
// - ON/OFF control, differential positive when cooling, negative heating.
// - Neutral zone cools with compressor, heats with heater, one set point.
// - Dual mode heater uses heating set point and its own differential.
// - Turbo in dual mode gives neutral zone on the heating set point.
// - Three-mode cooling keeps cooling across Normal, Eco and Turbo.
// - Compressor protection always gates the compressor-function output.
// - Probe error cycles the compressor on and off by programmed times.
// - Error on-time off keeps it off; only off-time off keeps it on.
// - Control outputs yield to compressor and heater protection and to stand-by.
// - Input functions 1 to 3 are door sensors gating the internal light.
// - Input function 9 toggles the auxiliary output in mode 2.
module tctl_core
  import tctl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SEC_NS / `CLK_PERIOD_NS
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic [1:0] DI_PIN_I,
  input wire logic signed [15:0] TEMP_I,
  input wire logic PROBE_ERR_I,
  input wire logic INST_ON_I,
  input wire logic ECO_I,
  input wire logic TURBO_I,
  input wire logic DEFROST_I,
  input wire logic POSTDEF_I,
  input wire logic DEFROST2_I,
  input wire logic FAN_I,
  input wire logic COMP_BLOCK_I,
  input wire logic HEAT_BLOCK_I,
  input wire logic ALARM_I,
  input wire logic SILENCE_I,
  input wire logic KEY_PRESS_I,
  input wire logic KEY_AUX_I,
  input wire logic RTC_AUX_ON_I,
  input wire logic RTC_AUX_OFF_I,
  output logic [3:0] OUT_O,
  output logic BUZZER_O
);
  // A one-second tick must be at least one cycle long.
  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least 1");
  end

  // ****************************************************************
  // Bus slave and configuration registers
  // ****************************************************************
  logic [31:0] out_cfg_q, out_cfg_d, mode_cfg_q, mode_cfg_d;
  logic [31:0] sp_main_q, sp_main_d, sp_eco_q, sp_eco_d;
  logic [31:0] sp_heat_q, sp_heat_d, times_q, times_d;
  logic [31:0] rdata_q, rdata_d, status;
  logic [7:0] waddr_q, waddr_d;
  logic wpend_q, wpend_d, take;

  // Zero wait states: reads are muxed at the address phase.
  assign take = HSEL_I & HTRANS_I[1] & HREADY_I;
  always_comb begin
    out_cfg_d = out_cfg_q;
    mode_cfg_d = mode_cfg_q;
    sp_main_d = sp_main_q;
    sp_eco_d = sp_eco_q;
    sp_heat_d = sp_heat_q;
    times_d = times_q;
    wpend_d = take & HWRITE_I;
    waddr_d = take ? HADDR_I[7:0] : waddr_q;
    rdata_d = rdata_q;
    if (wpend_q) begin
      case (waddr_q)
        `OFS_OUT_CFG: out_cfg_d = {16'h0000, HWDATA_I[15:0]};
        `OFS_MODE_CFG: mode_cfg_d = {12'h000, HWDATA_I[19:0]};
        `OFS_SP_MAIN: sp_main_d = HWDATA_I;
        `OFS_SP_ECO: sp_eco_d = HWDATA_I;
        `OFS_SP_HEAT: sp_heat_d = HWDATA_I;
        `OFS_TIMES: times_d = HWDATA_I;
        default: ;
      endcase
    end
    if (take & ~HWRITE_I) begin
      case (HADDR_I[7:0])
        `OFS_OUT_CFG: rdata_d = out_cfg_q;
        `OFS_MODE_CFG: rdata_d = mode_cfg_q;
        `OFS_SP_MAIN: rdata_d = sp_main_q;
        `OFS_SP_ECO: rdata_d = sp_eco_q;
        `OFS_SP_HEAT: rdata_d = sp_heat_q;
        `OFS_TIMES: rdata_d = times_q;
        `OFS_STATUS: rdata_d = status;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      out_cfg_q <= `RST_OUT_CFG;
      mode_cfg_q <= `RST_MODE_CFG;
      sp_main_q <= `RST_SP;
      sp_eco_q <= `RST_SP;
      sp_heat_q <= `RST_SP;
      times_q <= `RST_TIMES;
      rdata_q <= 32'h00000000;
      waddr_q <= 8'h00;
      wpend_q <= 1'b0;
    end else if (CE_I) begin
      out_cfg_q <= out_cfg_d;
      mode_cfg_q <= mode_cfg_d;
      sp_main_q <= sp_main_d;
      sp_eco_q <= sp_eco_d;
      sp_heat_q <= sp_heat_d;
      times_q <= times_d;
      rdata_q <= rdata_d;
      waddr_q <= waddr_d;
      wpend_q <= wpend_d;
    end
  end
  assign HRDATA_O = rdata_q;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  ctrl_mode_type ctrl_mode;
  aux_mode_type aux_mode;
  buz_mode_type buz_mode;
  logic [4:0] di_fn [2];
  logic [7:0] aux_dly, aux_tmr, err_on, err_off;
  assign ctrl_mode = ctrl_mode_type'(mode_cfg_q[`MODE_CTRL_LSB +: 3]);
  assign aux_mode = aux_mode_type'(mode_cfg_q[`MODE_AUX_LSB +: 2]);
  assign buz_mode = buz_mode_type'(mode_cfg_q[`MODE_BUZ_LSB +: 2]);
  assign di_fn[0] = mode_cfg_q[`MODE_DI0_LSB +: 5];
  assign di_fn[1] = mode_cfg_q[`MODE_DI1_LSB +: 5];
  assign aux_dly = times_q[`TM_AUX_DLY_LSB +: 8];
  assign aux_tmr = times_q[`TM_AUX_TMR_LSB +: 8];
  assign err_on = times_q[`TM_ERR_ON_LSB +: 8];
  assign err_off = times_q[`TM_ERR_OFF_LSB +: 8];

  // ****************************************************************
  // Contact inputs: three-stage synchronisers with agreement filter
  // ****************************************************************
  logic [1:0] s1_q, s2_q, s3_q, di_q, di_d, dprev_q;
  logic door_open, aux_cmd;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      di_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : di_q[i];
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
      di_q <= 2'h0;
      dprev_q <= 2'h0;
    end else if (CE_I) begin
      s1_q <= DI_PIN_I;
      s2_q <= s1_q;
      s3_q <= s2_q;
      di_q <= di_d;
      dprev_q <= di_q;
    end
  end
  // Inputs sharing a function act as contacts in parallel.
  always_comb begin
    door_open = 1'b0;
    aux_cmd = KEY_AUX_I;
    for (int i = 0; i < 2; i++) begin
      if (di_fn[i] >= `DI_DOOR_MIN && di_fn[i] <= `DI_DOOR_MAX) begin
        door_open = door_open | di_q[i];
      end
      if (di_fn[i] == `DI_AUX_CMD) begin
        aux_cmd = aux_cmd | (di_q[i] & ~dprev_q[i]);
      end
    end
  end

  // ****************************************************************
  // Set point selection and ON/OFF comparators
  // ****************************************************************
  logic neutral, dual;
  logic signed [15:0] sp_act, df_act, sp_h, df_h;
  logic signed [16:0] t17, cool_hi, heat_lo;
  // Turbo in dual mode runs neutral zone on the heating point.
  assign dual = (ctrl_mode == CTRL_DUAL) & ~TURBO_I;
  assign neutral = (ctrl_mode == CTRL_NEUTRAL)
                 | ((ctrl_mode == CTRL_DUAL) & TURBO_I);
  always_comb begin
    if ((ctrl_mode == CTRL_DUAL) & TURBO_I) begin
      sp_act = sp_heat_q[15:0];
      df_act = sp_heat_q[31:16];
    end else if (ECO_I) begin
      sp_act = sp_eco_q[15:0];
      df_act = sp_eco_q[31:16];
    end else begin
      sp_act = sp_main_q[15:0];
      df_act = sp_main_q[31:16];
    end
    sp_h = dual ? sp_heat_q[15:0] : sp_act;
    df_h = dual ? sp_heat_q[31:16] : df_act;
  end
  assign t17 = 17'(TEMP_I);
  assign cool_hi = 17'(sp_act) + 17'(df_act);
  assign heat_lo = 17'(sp_h) - 17'(df_h);

  // ****************************************************************
  // Control state: hysteresis, seconds, probe error cycle, auxiliary
  // ****************************************************************
  logic cool_q, cool_d, heat_q, heat_d, aux_q, aux_d;
  logic tick, comp_on, heater_on, pe_out;
  logic [31:0] sec_q, sec_d;
  logic [7:0] pe_cnt_q, pe_cnt_d, aux_cnt_q, aux_cnt_d;
  pe_phase_type pe_q, pe_d;

  assign tick = sec_q == 32'(TICK_CYCLES - 1);
  // Open on-time gives off; open off-time alone gives on.
  assign pe_out = (err_on == 8'h00) ? 1'b0 :
                  (err_off == 8'h00) ? 1'b1 : (pe_q == PE_ON);
  // Overrides and standby always win over the demand.
  always_comb begin
    if (PROBE_ERR_I) begin
      comp_on = pe_out;
    end else if (ctrl_mode == CTRL_HEAT) begin
      comp_on = heat_q;
    end else begin
      comp_on = cool_q;
    end
    comp_on = comp_on & INST_ON_I & ~COMP_BLOCK_I;
    heater_on = (neutral | dual) & heat_q & INST_ON_I
              & ~PROBE_ERR_I & ~HEAT_BLOCK_I;
  end

  always_comb begin
    sec_d = tick ? 32'h00000000 : sec_q + 32'h00000001;
    cool_d = cool_q;
    heat_d = heat_q;
    if (t17 >= cool_hi) begin
      cool_d = 1'b1;
    end else if (TEMP_I <= sp_act) begin
      cool_d = 1'b0;
    end
    if (t17 <= heat_lo) begin
      heat_d = 1'b1;
    end else if (TEMP_I >= sp_h) begin
      heat_d = 1'b0;
    end
    // Probe error phases reload their time on each change.
    pe_d = pe_q;
    pe_cnt_d = pe_cnt_q;
    if (!PROBE_ERR_I) begin
      pe_d = PE_ON;
      pe_cnt_d = err_on;
    end else if (tick) begin
      if (pe_cnt_q <= 8'h01) begin
        pe_d = (pe_q == PE_ON) ? PE_OFF : PE_ON;
        pe_cnt_d = (pe_q == PE_ON) ? err_off : err_on;
      end else begin
        pe_cnt_d = pe_cnt_q - 8'h01;
      end
    end
    aux_d = aux_q;
    aux_cnt_d = aux_cnt_q;
    case (aux_mode)
      AUX_OFF: begin
        aux_d = 1'b0;
        aux_cnt_d = 8'h00;
      end
      AUX_DELAY: begin
        if (!comp_on) begin
          aux_d = 1'b0;
          aux_cnt_d = aux_dly;
        end else if (aux_cnt_q == 8'h00) begin
          aux_d = 1'b1;
        end else if (tick) begin
          aux_cnt_d = aux_cnt_q - 8'h01;
        end
      end
      AUX_TOGGLE: begin
        // A command after a clock event holds until the next event.
        if (aux_cmd) begin
          aux_d = ~aux_q;
          aux_cnt_d = aux_tmr;
        end else if (RTC_AUX_ON_I | RTC_AUX_OFF_I) begin
          aux_d = RTC_AUX_ON_I;
          aux_cnt_d = aux_tmr;
        end else if (!aux_q || aux_tmr == 8'h00) begin
          aux_cnt_d = aux_tmr;
        end else if (tick) begin
          if (aux_cnt_q <= 8'h01) begin
            aux_d = 1'b0;
          end
          aux_cnt_d = aux_cnt_q - 8'h01;
        end
      end
      AUX_SUCTION: begin
        aux_d = INST_ON_I & ~DEFROST_I & ~POSTDEF_I;
      end
      default: aux_d = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sec_q <= 32'h00000000;
      cool_q <= 1'b0;
      heat_q <= 1'b0;
      pe_q <= PE_ON;
      pe_cnt_q <= 8'h00;
      aux_q <= 1'b0;
      aux_cnt_q <= 8'h00;
    end else if (CE_I) begin
      sec_q <= sec_d;
      cool_q <= cool_d;
      heat_q <= heat_d;
      pe_q <= pe_d;
      pe_cnt_q <= pe_cnt_d;
      aux_q <= aux_d;
      aux_cnt_q <= aux_cnt_d;
    end
  end

  // ****************************************************************
  // Alarm memory, output assignment and buzzer
  // ****************************************************************
  logic sil_q, sil_d, mem_q, mem_d, buz_q, buz_d, snd;
  logic [3:0] out_q, out_d;
  // Memory clears only by silencing once the alarm is gone.
  assign sil_d = ALARM_I & (sil_q | SILENCE_I);
  assign mem_d = ALARM_I | (mem_q & ~SILENCE_I);
  assign snd = ALARM_I & ~sil_q;

  for (genvar g = 0; g < 4; g++) begin : g_out
    always_comb begin
      case (out_fn_type'(out_cfg_q[g*4 +: 4]))
        OUT_COMP: out_d[g] = comp_on;
        OUT_DEFROST: out_d[g] = DEFROST_I;
        OUT_FAN: out_d[g] = FAN_I;
        OUT_AUX: out_d[g] = aux_q;
        ALM_SIL_NO: out_d[g] = snd;
        ALM_NSIL_NO: out_d[g] = ALARM_I;
        ALM_MEM_NO: out_d[g] = ALARM_I | mem_q;
        ALM_SIL_NC: out_d[g] = ~snd;
        ALM_NSIL_NC: out_d[g] = ~ALARM_I;
        ALM_MEM_NC: out_d[g] = ~(ALARM_I | mem_q);
        OUT_INST_ON: out_d[g] = INST_ON_I;
        OUT_HEATER: out_d[g] = heater_on;
        OUT_DEFROST2: out_d[g] = DEFROST2_I;
        OUT_SHOP_LIGHT: out_d[g] = ~ECO_I;
        OUT_INT_LIGHT: out_d[g] = door_open;
        default: out_d[g] = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (buz_mode)
      BUZ_ALARM: buz_d = snd;
      BUZ_KEY: buz_d = KEY_PRESS_I;
      BUZ_BOTH: buz_d = snd | KEY_PRESS_I;
      default: buz_d = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      sil_q <= 1'b0;
      mem_q <= 1'b0;
      out_q <= 4'h0;
      buz_q <= 1'b0;
    end else if (CE_I) begin
      sil_q <= sil_d;
      mem_q <= mem_d;
      out_q <= out_d;
      buz_q <= buz_d;
    end
  end
  assign OUT_O = out_q;
  assign BUZZER_O = buz_q;
  assign status = {21'h000000, door_open, heat_q, cool_q, mem_q,
                   aux_q, buz_q, pe_q == PE_OFF, out_q};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  a_aux_off_idle: assert property (
    CE_I && aux_mode == AUX_OFF |=> !aux_q
  ) else $error("aux on while aux mode off");
  a_aux_follows_comp: assert property (
    CE_I && aux_mode == AUX_DELAY && !comp_on |=> !aux_q
  ) else $error("aux on without compressor");
  a_aux_toggle_on: assert property (
    CE_I && aux_mode == AUX_TOGGLE && aux_cmd && !aux_q |=> aux_q
  ) else $error("aux command did not switch on");
  a_suction_defrost: assert property (
    CE_I && aux_mode == AUX_SUCTION && DEFROST_I |=> !aux_q
  ) else $error("suction valve open in defrost");
  a_buzzer_off: assert property (
    CE_I && buz_mode == BUZ_OFF |=> !BUZZER_O
  ) else $error("buzzer sounds while disabled");
  a_cool_start: assert property (
    CE_I && t17 >= cool_hi |=> cool_q
  ) else $error("cooling demand not raised");
  a_pe_off_time: assert property (
    PROBE_ERR_I && err_on == 8'h00 |-> !comp_on
  ) else $error("compressor on with error on-time off");
  a_comp_block: assert property (
    CE_I && COMP_BLOCK_I && out_cfg_q[3:0] == 4'h0 |=> !OUT_O[0]
  ) else $error("protected compressor output switched on");
  a_out_disabled: assert property (
    CE_I && out_cfg_q[7:4] == 4'hF |=> !OUT_O[1]
  ) else $error("disabled output active");
endmodule
`default_nettype wire

// file: tctl_defines.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef TCTL_DEFINES_SVH
`define TCTL_DEFINES_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_OUT_CFG 8'h00
`define OFS_MODE_CFG 8'h04
`define OFS_SP_MAIN 8'h08
`define OFS_SP_ECO 8'h0C
`define OFS_SP_HEAT 8'h10
`define OFS_TIMES 8'h14
`define OFS_STATUS 8'h18
// ****************************************************************
// Field positions
// ****************************************************************
`define MODE_CTRL_LSB 0
`define MODE_AUX_LSB 4
`define MODE_BUZ_LSB 8
`define MODE_DI0_LSB 10
`define MODE_DI1_LSB 15
`define SP_DIFF_LSB 16
`define TM_AUX_DLY_LSB 0
`define TM_AUX_TMR_LSB 8
`define TM_ERR_ON_LSB 16
`define TM_ERR_OFF_LSB 24
// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RST_OUT_CFG 32'h0000FFFF
`define RST_MODE_CFG 32'h00000000
`define RST_SP 32'h00000000
`define RST_TIMES 32'h00000000
`define DI_DOOR_MIN 5'h01
`define DI_DOOR_MAX 5'h03
`define DI_AUX_CMD 5'h09
// ****************************************************************
// Timing
// ****************************************************************
`define SEC_NS 1000000000
`define CLK_PERIOD_NS 10
`endif

// file: tctl_pkg.sv
// Types shared by the output assignment and ON/OFF control block.
package tctl_pkg;
  typedef enum logic [3:0] {
    OUT_COMP, OUT_DEFROST, OUT_FAN, OUT_AUX,
    ALM_SIL_NO, ALM_NSIL_NO, ALM_MEM_NO,
    ALM_SIL_NC, ALM_NSIL_NC, ALM_MEM_NC,
    OUT_INST_ON, OUT_HEATER, OUT_DEFROST2,
    OUT_SHOP_LIGHT, OUT_INT_LIGHT, OUT_DISABLED
  } out_fn_type;
  typedef enum logic [2:0] {
    CTRL_COOL, CTRL_HEAT, CTRL_NEUTRAL, CTRL_DUAL, CTRL_THREE
  } ctrl_mode_type;
  typedef enum logic [1:0] {
    AUX_OFF, AUX_DELAY, AUX_TOGGLE, AUX_SUCTION
  } aux_mode_type;
  typedef enum logic [1:0] {
    BUZ_OFF, BUZ_ALARM, BUZ_KEY, BUZ_BOTH
  } buz_mode_type;
  typedef enum logic {PE_ON, PE_OFF} pe_phase_type;
endpackage

// file: tctl_env_model.sv
// Model of the probe and contact wiring that faces the control block.
`timescale 1ns/1ps
`default_nettype none
module tctl_env_model (
  input wire logic clk_i,
  input wire logic door_open_i,
  input wire logic remote_cmd_i,
  input wire logic fault_i,
  input wire logic [15:0] temp_i,
  output logic [1:0] contact_o,
  output logic [15:0] probe_o,
  output logic probe_err_o
);
  // ****************************************
  // Field wiring
  // ****************************************
  // A broken probe gives a reading that flips every cycle, never a tidy
  // value, so logic that trusts it during a fault shows up at once.
  always @(posedge clk_i) begin
    contact_o[0] <= door_open_i;
    contact_o[1] <= remote_cmd_i;
    probe_err_o <= fault_i;
    probe_o <= fault_i ? ~probe_o : temp_i;
  end
endmodule
`default_nettype wire

// file: tctl_core_tb.sv
// Self-checking testbench for the output assignment and control block.
`timescale 1ns/1ps
`default_nettype none
`include "tctl_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("wrong value at %0t: %0h %0h", $time, g, e); \
  end end
module tctl_core_tb
  import tctl_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] pls = 5'h00;
  logic inst = 1'b1;
  logic alarm = 1'b0;
  logic eco = 1'b0;
  logic turbo = 1'b0;
  logic defr = 1'b0;
  logic postd = 1'b0;
  logic cblk = 1'b0;
  logic ce = 1'b1;
  logic hblk = 1'b0;
  logic door = 1'b0;
  logic rcmd = 1'b0;
  logic fault = 1'b0;
  logic [15:0] tval = 16'h0000;
  wire [31:0] hrdata;
  wire hready;
  wire hresp;
  wire [1:0] di;
  wire [15:0] temp;
  wire err;
  wire [3:0] outs;
  wire buz;
  int bad_count = 0;
  int checks_done = 0;
  // One second is ten cycles here, so every timer runs in a short window.
  tctl_core #(.TICK_CYCLES(10)) i_tctl_core (
    .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .DI_PIN_I(di), .TEMP_I(temp), .PROBE_ERR_I(err), .INST_ON_I(inst),
    .ECO_I(eco), .TURBO_I(turbo), .DEFROST_I(defr), .POSTDEF_I(postd),
    .DEFROST2_I(1'b0), .FAN_I(1'b0), .COMP_BLOCK_I(cblk),
    .HEAT_BLOCK_I(hblk), .ALARM_I(alarm), .SILENCE_I(pls[3]),
    .KEY_PRESS_I(pls[4]), .KEY_AUX_I(pls[0]), .RTC_AUX_ON_I(pls[1]),
    .RTC_AUX_OFF_I(pls[2]), .OUT_O(outs), .BUZZER_O(buz)
  );
  tctl_env_model i_tctl_env_model (
    .clk_i(clk), .door_open_i(door), .remote_cmd_i(rcmd),
    .fault_i(fault), .temp_i(tval), .contact_o(di), .probe_o(temp),
    .probe_err_o(err)
  );
  // Free-running system clock.
  initial begin
    forever #5 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Every task is entered just after a rising edge; changes go by NBA.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task cfg(input logic [15:0] o, input logic [31:0] m);
    wr(`OFS_OUT_CFG, {16'h0, o});
    wr(`OFS_MODE_CFG, m);
  endtask
  // A one-cycle event pulse, then time for it to reach the relays.
  task pulse(input int i);
    pls[i] <= 1'b1;
    tick(1);
    pls <= 5'h00;
    tick(4);
  endtask
  task count_on(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      c += (outs[0] === 1'b1);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    logic [31:0] q;
    bus(1'b0, `OFS_OUT_CFG, 32'h0, q);
    `CHK(q, `RST_OUT_CFG)
    wr(8'h20, 32'h12345678);
    bus(1'b0, 8'h20, 32'h0, q);
    `CHK(q, 32'h0)
    wr(`OFS_SP_ECO, 32'h0005FFF0);
    bus(1'b0, `OFS_SP_ECO, 32'h0, q);
    `CHK(q, 32'h0005FFF0)
    `CHK(hresp, 1'b0)
    $display("test regs done");
  endtask
  task t_ctrl;
    wr(`OFS_SP_MAIN, 32'h000A0000);
    wr(`OFS_SP_HEAT, 32'h0005FFEC);
    cfg({OUT_DISABLED, OUT_DISABLED, OUT_HEATER, OUT_COMP}, 32'h0);
    tval <= 16'd10; tick(6); `CHK(outs[0], 1'b1)
    tval <= 16'd5; tick(6); `CHK(outs[0], 1'b1)
    tval <= 16'd0; tick(6); `CHK(outs[0], 1'b0)
    tval <= 16'd5; tick(6); `CHK(outs[0], 1'b0)
    tval <= 16'd20; cblk <= 1'b1; tick(6); `CHK(outs[0], 1'b0)
    cblk <= 1'b0; tick(6); `CHK(outs[0], 1'b1)
    // With the enable low every flop holds, so the demand cannot drop.
    ce <= 1'b0;
    tval <= 16'd0;
    tick(6);
    `CHK(outs[0], 1'b1)
    ce <= 1'b1;
    tick(6);
    `CHK(outs[0], 1'b0)
    wr(`OFS_MODE_CFG, 32'h2);
    tval <= -16'sd10; tick(6); `CHK(outs[1:0], 2'b10)
    // The heater override must win over a standing heating demand.
    hblk <= 1'b1;
    tick(4);
    `CHK(outs[1:0], 2'b00)
    hblk <= 1'b0;
    tval <= 16'd10; tick(6); `CHK(outs[1:0], 2'b01)
    wr(`OFS_MODE_CFG, 32'h1);
    tval <= -16'sd10; tick(6); `CHK(outs[0], 1'b1)
    tval <= -16'sd5; tick(6); `CHK(outs[0], 1'b1)
    wr(`OFS_MODE_CFG, 32'h3);
    tval <= -16'sd10; tick(6); `CHK(outs[1:0], 2'b00)
    tval <= -16'sd30; tick(6); `CHK(outs[1:0], 2'b10)
    tval <= -16'sd10; turbo <= 1'b1; tick(6); `CHK(outs[1:0], 2'b01)
    turbo <= 1'b0;
    wr(`OFS_MODE_CFG, 32'h4);
    eco <= 1'b1; tval <= -16'sd20; tick(6); `CHK(outs[0], 1'b0)
    tval <= -16'sd10; tick(6); `CHK(outs[0], 1'b1)
    eco <= 1'b0;
    tval <= 16'd0;
    $display("test control done");
  endtask
  task t_alarm;
    cfg({OUT_SHOP_LIGHT, OUT_INST_ON, ALM_NSIL_NC, ALM_NSIL_NO}, 32'h100);
    tick(4); `CHK(outs, 4'b1110)
    alarm <= 1'b1; eco <= 1'b1; tick(4); `CHK(outs, 4'b0101)
    `CHK(buz, 1'b1)
    alarm <= 1'b0; eco <= 1'b0; inst <= 1'b0; tick(4); `CHK(outs[2], 1'b0)
    `CHK(buz, 1'b0)
    inst <= 1'b1;
    cfg({OUT_DISABLED, ALM_SIL_NO, ALM_MEM_NC, ALM_MEM_NO}, 32'h200);
    pulse(3); `CHK(outs, 4'b0010)
    alarm <= 1'b1; tick(4); `CHK(outs, 4'b0101)
    pulse(3); `CHK(outs, 4'b0001)
    alarm <= 1'b0; tick(4); `CHK(outs, 4'b0001)
    pulse(3); `CHK(outs, 4'b0010)
    pulse(4); `CHK(buz, 1'b0)
    pls[4] <= 1'b1; tick(3); `CHK(buz, 1'b1)
    pls[4] <= 1'b0;
    $display("test alarm done");
  endtask
  task t_aux;
    cfg({OUT_DISABLED, OUT_DISABLED, OUT_DISABLED, OUT_AUX}, 32'h48020);
    tick(4); `CHK(outs[0], 1'b0)
    pulse(0); `CHK(outs[0], 1'b1)
    pulse(0); `CHK(outs[0], 1'b0)
    pulse(1); `CHK(outs[0], 1'b1)
    pulse(0); `CHK(outs[0], 1'b0)
    pulse(1); `CHK(outs[0], 1'b1)
    pulse(2); `CHK(outs[0], 1'b0)
    rcmd <= 1'b1; tick(8); `CHK(outs[0], 1'b1)
    rcmd <= 1'b0; tick(8); `CHK(outs[0], 1'b1)
    rcmd <= 1'b1; tick(8); `CHK(outs[0], 1'b0)
    rcmd <= 1'b0;
    wr(`OFS_TIMES, 32'h00000300);
    pulse(0); `CHK(outs[0], 1'b1)
    tick(40); `CHK(outs[0], 1'b0)
    cfg({OUT_DISABLED, OUT_DISABLED, OUT_COMP, OUT_AUX}, 32'h10);
    wr(`OFS_TIMES, 32'h2);
    tval <= 16'd20; tick(5); `CHK(outs[1:0], 2'b10)
    tick(30); `CHK(outs[1:0], 2'b11)
    tval <= 16'd0; tick(5); `CHK(outs[1:0], 2'b00)
    cfg({OUT_DISABLED, OUT_DISABLED, OUT_DEFROST, OUT_AUX}, 32'h30);
    tick(4); `CHK(outs[0], 1'b1)
    defr <= 1'b1; tick(4); `CHK(outs[1:0], 2'b10)
    defr <= 1'b0; postd <= 1'b1; tick(4); `CHK(outs[0], 1'b0)
    postd <= 1'b0; tick(4); `CHK(outs[0], 1'b1)
    wr(`OFS_MODE_CFG, 32'h0);
    tick(4); `CHK(outs[0], 1'b0)
    $display("test aux done");
  endtask
  task t_err;
    int c;
    cfg({OUT_DISABLED, OUT_DISABLED, OUT_DISABLED, OUT_COMP}, 32'h0);
    wr(`OFS_TIMES, 32'h03020000);
    fault <= 1'b1; tick(4); `CHK(outs[0], 1'b1)
    count_on(100, c); `CHK(c >= 15 && c <= 45, 1'b1)
    wr(`OFS_TIMES, 32'h03000000);
    tick(30); count_on(60, c); `CHK(c, 0)
    wr(`OFS_TIMES, 32'h00020000);
    tick(30); count_on(60, c); `CHK(c, 60)
    fault <= 1'b0; tick(6); `CHK(outs[0], 1'b0)
    $display("test probe error done");
  endtask
  task t_light;
    logic [31:0] q;
    cfg({OUT_DISABLED, OUT_DISABLED, OUT_DISABLED, OUT_INT_LIGHT}, 32'h400);
    door <= 1'b1; tick(8); `CHK(outs[0], 1'b1)
    // Status shows the filtered door contact and the relay image.
    bus(1'b0, `OFS_STATUS, 32'h0, q);
    `CHK(q, 32'h00000401)
    door <= 1'b0; tick(8); `CHK(outs[0], 1'b0)
    wr(`OFS_MODE_CFG, 32'h1000);
    door <= 1'b1; tick(8); `CHK(outs[0], 1'b0)
    door <= 1'b0;
    $display("test light done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    tick(4);
    rst <= 1'b0;
    t_regs;
    t_ctrl;
    t_alarm;
    t_aux;
    t_err;
    t_light;
    end_of_test;
  end
  // The tests need about 700 cycles; reaching the 20000-cycle limit means a hang.
  initial begin
    tick(20000);
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
